// file: design/mtc_pkg.sv
// Package with the register map, field layout and carrier types of the tape controller.
package mtc_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MOTION = 8'h0c;
    localparam logic [7:0] ADDR_WCHAR = 8'h10;
    localparam logic [7:0] ADDR_RCHAR = 8'h14;
    localparam logic [7:0] ADDR_RCTL = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_CHAN = 8'h24;
    localparam logic [7:0] ADDR_VECT = 8'h28;

    // Setup order selection bits, highest first.
    localparam int SEL_STATUS = 15;
    localparam int SEL_ID = 14;
    localparam int SEL_CHAN = 13;
    localparam int SEL_VECT = 12;

    // Identification number returned by the setup order; the value is arbitrary.
    localparam logic [15:0] DEVICE_ID = 16'h005a;

    // Status word bit positions; bit 15 is the first bit of the word.
    localparam int ST_VPE = 15;
    localparam int ST_LRC = 12;
    localparam int ST_READY = 7;
    localparam int ST_ONLINE = 6;
    localparam int ST_EOT = 5;
    localparam int ST_REWINDING = 4;
    localparam int ST_LOAD_POINT = 3;
    localparam int ST_PROTECT = 2;
    localparam int ST_OVERRUN = 1;
    localparam int ST_REWIND_INT = 0;

    // Motion order fields.
    localparam int MO_FWD = 4;
    localparam int MO_REV = 5;
    localparam int MO_RWD = 6;
    localparam int MO_WRT = 7;
    localparam logic [3:0] UNIT_0 = 4'h8;

    // Write character register: bit 8 asks for the check character strobe.
    localparam int WC_CHECK = 8;
    // Read control register: bit 0 marks the end of a record.
    localparam int RC_EOR = 0;

    // Interrupt status and mask layout.
    localparam int IRQ_W = 5;
    localparam int IRQ_READY = 0;
    localparam int IRQ_RCHAR = 1;
    localparam int IRQ_REWIND = 2;
    localparam int IRQ_ILLEGAL = 3;
    localparam int IRQ_ERROR = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Transport condition lines of the selected transport.
    typedef struct packed {
        logic ready;
        logic online;
        logic end_of_tape_line;
        logic rewinding;
        logic load_point;
        logic file_protect;
    } mtc_cond_t;

    // Motion command lines with one-hot transport select, bit 0 is transport 0.
    typedef struct packed {
        logic forward_command;
        logic reverse_command;
        logic rewind_command;
        logic write_command;
        logic [3:0] select;
    } mtc_motion_t;

    // One tape character with its parity bit.
    typedef struct packed {
        logic [7:0] data;
        logic parity;
    } mtc_char_t;

    // Odd parity bit over one character.
    function automatic logic odd_parity(input logic [7:0] d);
        return ~(^d);
    endfunction

endpackage

// file: design/mtc_read_check.sv
// Read character capture with vertical parity and longitudinal check.
`timescale 1ns/100ps

module mtc_read_check (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Transport read side
    input wire logic [7:0] read_char_lines,
    input wire logic read_parity_line,
    input wire logic read_char_strobe,
    // Control from the controller
    input wire logic end_of_record,
    // Results
    output mtc_pkg::mtc_char_t char_out,
    output logic char_valid,
    output logic parity_err,
    output logic lrc_err
);

    typedef struct packed {
        logic strobe_prev;
        mtc_pkg::mtc_char_t chr;
        logic valid;
        logic perr;
        logic [8:0] lrc;
        logic lrc_bad;
    } mtc_rc_state_t;

    mtc_rc_state_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        s_next.perr = 1'b0;
        s_next.lrc_bad = 1'b0;
        s_next.strobe_prev = read_char_strobe;
        // Capture once per strobe, on its rising edge, so a long strobe is one character.
        if (read_char_strobe && !s_reg.strobe_prev) begin
            s_next.chr = '{data: read_char_lines, parity: read_parity_line};
            s_next.valid = 1'b1;
            s_next.perr = (mtc_pkg::odd_parity(read_char_lines) != read_parity_line);
            s_next.lrc = s_reg.lrc ^ {read_char_lines, read_parity_line};
        end
        // The check character itself folds into the sum, so a good record leaves zero.
        if (end_of_record) begin
            s_next.lrc_bad = |s_next.lrc;
            s_next.lrc = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign char_out = s_reg.chr;
    assign char_valid = s_reg.valid;
    assign parity_err = s_reg.perr;
    assign lrc_err = s_reg.lrc_bad;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rchar_capture_a: assert property (read_char_strobe && !s_reg.strobe_prev |=>
        char_out.data == $past(read_char_lines) && char_valid)
        else $error("read character not captured on strobe");
    rparity_capture_a: assert property (read_char_strobe && !s_reg.strobe_prev |=>
        char_out.parity == $past(read_parity_line) ##1 !char_valid)
        else $error("read parity not captured or strobe counted twice");

endmodule

// file: design/mtc_ctrl.sv
// Tape controller top: AXI4-Lite registers, setup data register, status word, transport lines.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps

module mtc_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Transport write side
    output logic [7:0] write_char_lines,
    output logic write_parity,
    output logic write_char_strobe,
    output logic check_char_strobe,
    output mtc_pkg::mtc_motion_t motion_command_lines,
    // Transport read side
    input mtc_pkg::mtc_cond_t transport_condition_lines,
    input wire logic [7:0] read_char_lines,
    input wire logic read_parity_line,
    input wire logic read_char_strobe
);

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic setup_pend;
        logic [15:0] setup_val;
        logic [15:0] hold;
        logic data_ready;
        logic vpe;
        logic lrc_err;
        logic ovr;
        logic rwi;
        mtc_pkg::mtc_cond_t cond;
        mtc_pkg::mtc_motion_t motion;
        logic [7:0] wchar;
        logic wpar;
        logic wpend;
        logic wstb;
        logic lstb;
        mtc_pkg::mtc_char_t rchar;
        logic rchar_full;
        logic eor;
        logic [mtc_pkg::IRQ_W-1:0] irq_stat;
        logic [mtc_pkg::IRQ_W-1:0] irq_mask;
        logic [15:0] chan;
        logic [15:0] vect;
    } mtc_state_t;

    mtc_state_t s_reg, s_next;

    logic [15:0] status_word;
    logic do_write;
    logic do_read;
    logic [31:0] wd;
    logic [mtc_pkg::IRQ_W-1:0] irq_set;
    logic [mtc_pkg::IRQ_W-1:0] irq_clr;
    logic [3:0] unit;
    logic motion_ok;
    mtc_pkg::mtc_char_t rc_char;
    logic rc_valid;
    logic rc_perr;
    logic rc_lrc;

    // Unstrobed byte lanes read as zero, so partial writes never carry stale bits.
    function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] strb);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    mtc_read_check u_read_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .read_char_lines(read_char_lines),
        .read_parity_line(read_parity_line),
        .read_char_strobe(read_char_strobe),
        .end_of_record(s_reg.eor),
        .char_out(rc_char),
        .char_valid(rc_valid),
        .parity_err(rc_perr),
        .lrc_err(rc_lrc)
    );

    always_comb begin
        status_word = '0;
        status_word[mtc_pkg::ST_VPE] = s_reg.vpe;
        status_word[mtc_pkg::ST_LRC] = s_reg.lrc_err;
        status_word[mtc_pkg::ST_READY] = s_reg.cond.ready;
        status_word[mtc_pkg::ST_ONLINE] = s_reg.cond.online;
        status_word[mtc_pkg::ST_EOT] = s_reg.cond.end_of_tape_line;
        status_word[mtc_pkg::ST_REWINDING] = s_reg.cond.rewinding;
        status_word[mtc_pkg::ST_LOAD_POINT] = s_reg.cond.load_point;
        status_word[mtc_pkg::ST_PROTECT] = s_reg.cond.file_protect;
        status_word[mtc_pkg::ST_OVERRUN] = s_reg.ovr;
        status_word[mtc_pkg::ST_REWIND_INT] = s_reg.rwi;
    end

    assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    assign do_read = s_axi_arvalid && !s_reg.rvalid;
    assign wd = lanes(s_reg.w_data, s_reg.w_strb);
    assign unit = wd[3:0];
    // A motion command needs a ready transport; a bare select does not.
    assign motion_ok = $onehot(unit) && (s_reg.cond.ready || wd[mtc_pkg::MO_WRT:mtc_pkg::MO_FWD] == 4'h0);

    always_comb begin
        s_next = s_reg;
        irq_set = '0;
        irq_clr = '0;
        s_next.wstb = 1'b0;
        s_next.lstb = 1'b0;
        s_next.eor = 1'b0;
        s_next.setup_pend = 1'b0;
        s_next.cond = transport_condition_lines;

        // Write channel bookkeeping; address and data may arrive in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Write strobe trails the data by one cycle so the lines are settled first.
        if (s_reg.wpend) begin
            s_next.wstb = 1'b1;
            s_next.wpend = 1'b0;
        end

        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = mtc_pkg::RESP_OKAY;
            case ({s_reg.aw_addr[7:2], 2'b00})
                mtc_pkg::ADDR_SETUP: begin
                    s_next.setup_pend = 1'b1;
                    s_next.setup_val = wd[15:0];
                end
                mtc_pkg::ADDR_MOTION: begin
                    if (motion_ok) begin
                        s_next.motion.forward_command = wd[mtc_pkg::MO_FWD];
                        s_next.motion.reverse_command = wd[mtc_pkg::MO_REV];
                        s_next.motion.rewind_command = wd[mtc_pkg::MO_RWD];
                        s_next.motion.write_command = wd[mtc_pkg::MO_WRT];
                        s_next.motion.select = {unit[0], unit[1], unit[2], unit[3]};
                        // A new operation starts with clean error flags.
                        s_next.vpe = 1'b0;
                        s_next.lrc_err = 1'b0;
                        s_next.ovr = 1'b0;
                        s_next.rwi = 1'b0;
                    end else begin
                        irq_set[mtc_pkg::IRQ_ILLEGAL] = 1'b1;
                    end
                end
                mtc_pkg::ADDR_WCHAR: begin
                    if (wd[mtc_pkg::WC_CHECK]) begin
                        s_next.lstb = 1'b1;
                    end else begin
                        s_next.wchar = wd[7:0];
                        s_next.wpar = mtc_pkg::odd_parity(wd[7:0]);
                        s_next.wpend = 1'b1;
                    end
                end
                mtc_pkg::ADDR_RCTL: s_next.eor = wd[mtc_pkg::RC_EOR];
                mtc_pkg::ADDR_IRQ_STAT: irq_clr = wd[mtc_pkg::IRQ_W-1:0];
                mtc_pkg::ADDR_IRQ_MASK: s_next.irq_mask = wd[mtc_pkg::IRQ_W-1:0];
                mtc_pkg::ADDR_CHAN: s_next.chan = wd[15:0];
                mtc_pkg::ADDR_VECT: s_next.vect = wd[15:0];
                mtc_pkg::ADDR_DATA, mtc_pkg::ADDR_STATUS, mtc_pkg::ADDR_RCHAR: begin
                end
                default: s_next.bresp = mtc_pkg::RESP_SLVERR;
            endcase
        end

        // Read channel; reading the holding or read character register consumes it.
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (do_read) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = mtc_pkg::RESP_OKAY;
            s_next.rdata = '0;
            case ({s_axi_araddr[7:2], 2'b00})
                mtc_pkg::ADDR_SETUP: s_next.rdata[15:0] = s_reg.setup_val;
                mtc_pkg::ADDR_DATA: begin
                    s_next.rdata[15:0] = s_reg.hold;
                    s_next.rdata[16] = s_reg.data_ready;
                    s_next.data_ready = 1'b0;
                end
                mtc_pkg::ADDR_STATUS: s_next.rdata[15:0] = status_word;
                mtc_pkg::ADDR_MOTION: s_next.rdata[7:0] = {s_reg.motion.write_command,
                    s_reg.motion.rewind_command, s_reg.motion.reverse_command,
                    s_reg.motion.forward_command, s_reg.motion.select};
                mtc_pkg::ADDR_WCHAR: s_next.rdata[8:0] = {s_reg.wpar, s_reg.wchar};
                mtc_pkg::ADDR_RCHAR: begin
                    s_next.rdata[9:0] = {s_reg.rchar_full, s_reg.rchar.parity, s_reg.rchar.data};
                    s_next.rchar_full = 1'b0;
                end
                mtc_pkg::ADDR_RCTL: begin
                end
                mtc_pkg::ADDR_IRQ_STAT: s_next.rdata[mtc_pkg::IRQ_W-1:0] = s_reg.irq_stat;
                mtc_pkg::ADDR_IRQ_MASK: s_next.rdata[mtc_pkg::IRQ_W-1:0] = s_reg.irq_mask;
                mtc_pkg::ADDR_CHAN: s_next.rdata[15:0] = s_reg.chan;
                mtc_pkg::ADDR_VECT: s_next.rdata[15:0] = s_reg.vect;
                default: s_next.rresp = mtc_pkg::RESP_SLVERR;
            endcase
        end

        // Setup order, one cycle after the write; the highest selection bit wins.
        if (s_reg.setup_pend) begin
            if (s_reg.setup_val[mtc_pkg::SEL_STATUS]) begin
                s_next.hold = status_word;
            end else if (s_reg.setup_val[mtc_pkg::SEL_ID]) begin
                s_next.hold = mtc_pkg::DEVICE_ID;
            end else if (s_reg.setup_val[mtc_pkg::SEL_CHAN]) begin
                s_next.hold = s_reg.chan;
            end else if (s_reg.setup_val[mtc_pkg::SEL_VECT]) begin
                s_next.hold = s_reg.vect;
            end
            if (|s_reg.setup_val[mtc_pkg::SEL_STATUS:mtc_pkg::SEL_VECT]) begin
                // Set wins over a same-cycle input transfer.
                s_next.data_ready = 1'b1;
                irq_set[mtc_pkg::IRQ_READY] = 1'b1;
            end else begin
                irq_set[mtc_pkg::IRQ_ILLEGAL] = 1'b1;
            end
        end

        // Read characters; an uncollected character being overwritten is an overrun.
        if (rc_valid) begin
            s_next.rchar = rc_char;
            s_next.rchar_full = 1'b1;
            irq_set[mtc_pkg::IRQ_RCHAR] = 1'b1;
            if (s_reg.rchar_full) begin
                s_next.ovr = 1'b1;
            end
        end
        if (rc_perr) begin
            s_next.vpe = 1'b1;
        end
        if (rc_lrc) begin
            s_next.lrc_err = 1'b1;
        end
        if (rc_perr || rc_lrc || (rc_valid && s_reg.rchar_full)) begin
            irq_set[mtc_pkg::IRQ_ERROR] = 1'b1;
        end

        // Rewind ends at load point: flag it and interrupt.
        if (s_reg.cond.rewinding && !transport_condition_lines.rewinding && transport_condition_lines.load_point) begin
            s_next.rwi = 1'b1;
            irq_set[mtc_pkg::IRQ_REWIND] = 1'b1;
        end

        s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.wpar <= mtc_pkg::odd_parity(8'h00);
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
    assign write_char_lines = s_reg.wchar;
    assign write_parity = s_reg.wpar;
    assign write_char_strobe = s_reg.wstb;
    assign check_char_strobe = s_reg.lstb;
    assign motion_command_lines = s_reg.motion;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    setup_status_a: assert property (s_reg.setup_pend && s_reg.setup_val[mtc_pkg::SEL_STATUS] |=>
        s_reg.hold == $past(status_word))
        else $error("holding register missed the status word");
    setup_priority_a: assert property (s_reg.setup_pend && s_reg.setup_val[15:12] == 4'h3 |=>
        s_reg.hold == $past(s_reg.chan))
        else $error("lower selection bit was honoured");
    ready_set_a: assert property (s_reg.setup_pend && |s_reg.setup_val[15:12] |=> s_reg.data_ready)
        else $error("data ready not raised after load");
    ready_clear_a: assert property (do_read && s_axi_araddr[7:2] == 6'h01 && !s_reg.setup_pend |=>
        !s_reg.data_ready ##1 !s_reg.data_ready || $past(s_reg.setup_pend))
        else $error("data ready not cleared by input transfer");
    status_cond_a: assert property ($past(aresetn) |->
        status_word[mtc_pkg::ST_READY] == $past(transport_condition_lines.ready)
        && status_word[mtc_pkg::ST_PROTECT] == $past(transport_condition_lines.file_protect))
        else $error("status word does not follow transport lines");
    select_map_a: assert property (do_write && s_reg.aw_addr == mtc_pkg::ADDR_MOTION && motion_ok
        && unit == mtc_pkg::UNIT_0 |=> motion_command_lines.select == 4'h1)
        else $error("transport 0 not selected by code 8");
    write_parity_a: assert property (write_parity == mtc_pkg::odd_parity(write_char_lines))
        else $error("write parity wrong");
    write_strobe_a: assert property (do_write && s_reg.aw_addr == mtc_pkg::ADDR_WCHAR
        && !wd[mtc_pkg::WC_CHECK] |=> !write_char_strobe ##1 write_char_strobe ##1 !write_char_strobe)
        else $error("write strobe not one pulse per character");
    check_strobe_a: assert property (do_write && s_reg.aw_addr == mtc_pkg::ADDR_WCHAR
        && wd[mtc_pkg::WC_CHECK] |=> check_char_strobe ##1 !check_char_strobe && $stable(write_char_lines))
        else $error("check strobe not pulsed");
    not_ready_a: assert property (do_write && s_reg.aw_addr == mtc_pkg::ADDR_MOTION && !s_reg.cond.ready
        && |wd[7:4] |=> $stable(motion_command_lines) && s_reg.irq_stat[mtc_pkg::IRQ_ILLEGAL])
        else $error("motion order accepted while transport not ready");
    select_onehot_a: assert property ($onehot0(motion_command_lines.select))
        else $error("more than one transport selected");
    parity_flag_a: assert property (rc_perr |=> s_reg.vpe && status_word[mtc_pkg::ST_VPE])
        else $error("parity error not flagged");
    overrun_flag_a: assert property (rc_valid && s_reg.rchar_full |=> s_reg.ovr)
        else $error("overrun not flagged");

    setup_load_c: cover property (s_reg.setup_pend ##1 s_reg.data_ready ##[1:20] !s_reg.data_ready);
    motion_order_c: cover property (do_write && s_reg.aw_addr == mtc_pkg::ADDR_MOTION && motion_ok);
    write_char_c: cover property (write_char_strobe ##[1:20] check_char_strobe);
    read_char_c: cover property (rc_valid ##[1:20] rc_valid);

endmodule

// file: verification/mtc_tape_model.sv
// Behavioural tape transport that drives the condition and read character lines.
`timescale 1ns/100ps
module mtc_tape_model (
    // Clock
    input wire logic aclk,
    // Transport lines
    output mtc_pkg::mtc_cond_t transport_condition_lines,
    output logic [7:0] read_char_lines,
    output logic read_parity_line,
    output logic read_char_strobe
);
    // On line and not rewinding, so the ready line is high.
    initial begin
        transport_condition_lines = 6'h30;
        read_char_lines = 8'h00;
        read_parity_line = 1'h0;
        read_char_strobe = 1'h0;
    end
    task automatic set_cond(input mtc_pkg::mtc_cond_t c);
        begin
            transport_condition_lines <= c;
        end
    endtask
    task automatic send(input logic [7:0] c, input logic bad);
        begin
            read_char_lines <= c;
            // A set bad flag flips the parity so the controller's own check must fire.
            read_parity_line <= ~(^c) ^ bad;
            @(posedge aclk) read_char_strobe <= 1'h1;
            @(posedge aclk) read_char_strobe <= 1'h0;
            // Lines past their hold time show the inverse so a stale sample is caught.
            @(posedge aclk) read_char_lines <= ~c;
        end
    endtask
endmodule

// file: verification/mtc_ctrl_tb.sv
// Self-checking bench for the tape controller.
`timescale 1ns/100ps
module mtc_ctrl_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, write_char_lines, read_char_lines, d;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, write_parity;
    logic write_char_strobe, check_char_strobe, read_parity_line, read_char_strobe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    mtc_pkg::mtc_motion_t motion_command_lines;
    mtc_pkg::mtc_cond_t transport_condition_lines;
    int n_errors = 0, checks_done = 0, n_ws = 0, n_cs = 0, i, seed = 32'h3adddfc7;
    mtc_ctrl DUT (.*);
    mtc_tape_model tape (.*);
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) n_ws += write_char_strobe;
    always @(posedge aclk) n_cs += check_char_strobe;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        begin
            checks_done++;
            if (g !== e) begin
                n_errors++;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!(s_axi_bvalid && s_axi_bready));
            s_axi_bready <= 1'h0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
            // One idle edge keeps the next call from raising what was just lowered.
            @(posedge aclk);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
            s_axi_rready <= 1'h0;
            chk(s_axi_rdata, e);
            chk({30'h0, s_axi_rresp}, {30'h0, mtc_pkg::RESP_OKAY});
            @(posedge aclk);
        end
    endtask
    task automatic report_and_stop;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        wr(mtc_pkg::ADDR_SETUP, 32'hf000, mtc_pkg::RESP_OKAY);
        rd(mtc_pkg::ADDR_DATA, 32'h100c0);
        rd(mtc_pkg::ADDR_DATA, 32'h000c0);
        wr(mtc_pkg::ADDR_SETUP, 32'h7000, mtc_pkg::RESP_OKAY);
        rd(mtc_pkg::ADDR_DATA, {15'h0, 1'h1, mtc_pkg::DEVICE_ID});
        wr(8'h40, 32'h0, mtc_pkg::RESP_SLVERR);
        $display("setup test done");
        for (i = 0; i < 4; i++) begin
            wr(mtc_pkg::ADDR_MOTION, 32'h10 | (32'h8 >> i), mtc_pkg::RESP_OKAY);
            chk({24'h0, motion_command_lines}, {24'h0, 4'h8, 4'h1 << i});
        end
        wr(mtc_pkg::ADDR_IRQ_MASK, 32'h8, mtc_pkg::RESP_OKAY);
        wr(mtc_pkg::ADDR_MOTION, 32'h13, mtc_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({24'h0, motion_command_lines}, 32'h88);
        chk({31'h0, irq}, 32'h1);
        wr(mtc_pkg::ADDR_IRQ_STAT, 32'h8, mtc_pkg::RESP_OKAY);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(mtc_pkg::ADDR_STATUS, 32'hc0);
        $display("motion test done");
        d = 8'($random(seed));
        wr(mtc_pkg::ADDR_WCHAR, {24'h0, d}, mtc_pkg::RESP_OKAY);
        wr(mtc_pkg::ADDR_WCHAR, 32'h100, mtc_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({23'h0, write_parity, write_char_lines}, {23'h0, ~(^d), d});
        chk(n_ws, 1);
        chk(n_cs, 1);
        $display("write test done");
        d = 8'($random(seed));
        tape.send(d, 1'h0);
        repeat (3) @(posedge aclk);
        rd(mtc_pkg::ADDR_RCHAR, {23'h1, ~(^d), d});
        rd(mtc_pkg::ADDR_RCHAR, {23'h0, ~(^d), d});
        rd(mtc_pkg::ADDR_STATUS, 32'hc0);
        $display("read test done");
        d = 8'($random(seed));
        tape.send(d, 1'h1);
        @(posedge aclk);
        tape.send(d, 1'h0);
        repeat (3) @(posedge aclk);
        rd(mtc_pkg::ADDR_STATUS, 32'h80c2);
        tape.set_cond(6'h14);
        wr(mtc_pkg::ADDR_MOTION, 32'h18, mtc_pkg::RESP_OKAY);
        chk({24'h0, motion_command_lines}, 32'h88);
        tape.set_cond(6'h32);
        repeat (3) @(posedge aclk);
        rd(mtc_pkg::ADDR_STATUS, 32'h80cb);
        rd(mtc_pkg::ADDR_IRQ_STAT, 32'h1f);
        $display("error test done");
        report_and_stop();
    end
endmodule
